// ==== include/sps_params.svh ====
// Purpose: Offsets, field positions, reset values and counts of the serial port
// Assumes: Included by its bare name
// Notes:   Byte address of a register is four times its index
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH

// ============================================================
// Register indices
`define SPS_IDX_DATA     10'h021
`define SPS_IDX_CTRL     10'h022
`define SPS_IDX_CSR      10'h023
`define SPS_IDX_MASK     10'h024

// ============================================================
// Control fields
`define SPS_CTRL_IRQEN   7
`define SPS_CTRL_EN      6
`define SPS_CTRL_R2      5
`define SPS_CTRL_MASTER_SELECT    4
`define SPS_CTRL_CPOL    3
`define SPS_CTRL_CPHA    2
`define SPS_CTRL_R1      1
`define SPS_CTRL_R0      0

// ============================================================
// Control/status fields
`define SPS_CSR_DONE     7
`define SPS_CSR_WRITE_COLLISION_FLAG     6
`define SPS_CSR_OVR      5
`define SPS_CSR_MODE_FAULT_FLAG     4
`define SPS_CSR_SOD      2
`define SPS_CSR_SSM      1
`define SPS_CSR_SSI      0
`define SPS_CSR_FLAGS    8'hf0
`define SPS_CSR_WBITS    8'h07

// ============================================================
// Reset values and counts
`define SPS_DATA_RST     8'h00
`define SPS_CTRL_RST     8'h00
`define SPS_CSR_RST      8'h00
`define SPS_MASK_RST     8'h00
`define SPS_LAST_EDGE    4'hf
`define SPS_RATE_MAX     3'h5

`endif

// ==== include/sps_pkg.sv ====
// Purpose: Types shared by the serial port design
// Assumes: Nothing
// Notes:   Constants live in sps_params.svh
package sps_pkg;

    // ============================================================
    // Sequencer states
    typedef enum logic [1:0] {
        SPS_IDLE = 2'b00,
        SPS_MRUN = 2'b01,
        SPS_SRUN = 2'b10
    } sps_state_t;

    typedef logic [7:0] sps_byte_t;

endpackage

// ==== verilog/sps_rate_gen.sv ====
// Purpose: Half-bit tick for master serial clock
// Assumes: rate above the top code behaves as the top code
// Notes:   Half period is 2 << rate cycles
`timescale 1ns/10ps
`include "sps_params.svh"
module sps_rate_gen #(
    parameter int CNT_W = 7
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic [2:0] rate,
    output logic            tick
);

    // ============================================================
    // Divider
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] term;
    logic [2:0]       rate_eff;

    always_comb begin
        rate_eff = (rate > `SPS_RATE_MAX) ? `SPS_RATE_MAX : rate;
        term     = CNT_W'((CNT_W'(2) << rate_eff) - CNT_W'(1));
        tick     = run && (cnt_r == term);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (!run || tick) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

endmodule

// ==== verilog/sps_shift8.sv ====
// Purpose: Byte shift register, msb first
// Assumes: load has priority over shift
// Notes:   Same register serves transmit and receive
`timescale 1ns/10ps
module sps_shift8 #(
    parameter int W = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         shift,
    input  wire logic         shift_in,
    output logic [W-1:0]      q
);

    // ============================================================
    // Shifter
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else if (load) begin
            q <= load_val;
        end else if (shift) begin
            q <= {q[W-2:0], shift_in};
        end
    end

endmodule

// ==== verilog/sps_top.sv ====
// Purpose: Synchronous serial port, master or slave, behind an APB slave
// Assumes: Pins synchronous to sys_clk; one clock domain
// Notes:   Slave clock is oversampled, so it must stay slow against sys_clk
//
// Summary of operation
// - Full duplex on three lines; simplex on two with slave output disabled.
// - Works as master or slave; a second master pulling select low raises mode fault.
// - Master offers six clock rates from sys_clk, fastest one quarter.
// - Software programs serial clock idle polarity and sampling phase.
// - Phase 1 samples on second edge of a bit, phase 0 on first.
// - Flags for end of transfer, write collision, mode fault and overrun.
// - Master drives serial clock; slaves only receive it.
// - Software select frees the pin; internal select follows the level bit.
// - Slave phase 0 write without select going high raises write collision.
// - Data register is eight bits, msb at bit 7.
// - Control register fields; all bits reset to zero.
// - Control/status register fields; all bits reset to zero.
`timescale 1ns/10ps
`include "sps_params.svh"
module sps_top
    import sps_pkg::*;
#(
    parameter int AW    = 12,
    parameter int CNT_W = 7
) (
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    output logic               irq,
    input  wire logic          sck_in,
    output logic               sck_out,
    output logic               sck_oe,
    input  wire logic          mosi_in,
    output logic               mosi_out,
    output logic               mosi_oe,
    input  wire logic          miso_in,
    output logic               miso_out,
    output logic               miso_oe,
    input  wire logic          ss_n_in
);

    // ============================================================
    // Declarations
    sps_state_t state_r;
    sps_byte_t  ctrl_r;
    sps_byte_t  csr_r;
    sps_byte_t  mask_r;
    sps_byte_t  rx_buf_r;
    sps_byte_t  sh_q;
    sps_byte_t  rx_byte;
    sps_byte_t  rd_val;
    sps_byte_t  flag_set;
    sps_byte_t  flag_clr;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic [3:0]  edge_cnt_r;
    logic        sck_r;
    logic        sck_prev_r;
    logic        in_bit_r;
    logic        ss_high_seen_r;

    logic        setup_ph;
    logic        access_ph;
    logic        hit_data;
    logic        hit_ctrl;
    logic        hit_csr;
    logic        hit_mask;
    logic        wr_data;
    logic        wr_ctrl;
    logic        wr_csr;
    logic        wr_mask;

    logic        enabled;
    logic        is_master;
    logic        cpol;
    logic        cpha;
    logic [2:0]  rate;
    logic        ss_int;
    logic        slave_sel;
    logic        master_run;
    logic        tick;
    logic        edge_ev;
    logic        sample_edge;
    logic        drive_edge;
    logic        last_edge;
    logic        in_pin;
    logic        shift_en;
    logic        shift_in;
    logic        busy;
    logic        write_collision_flag_ev;
    logic        mode_fault_flag_ev;
    logic        ovr_ev;
    logic        load_en;
    logic        start_master;

    // ============================================================
    // APB decode
    always_comb begin
        setup_ph  = psel && !penable;
        access_ph = psel && penable;
        hit_data  = (paddr == AW'({`SPS_IDX_DATA, 2'b00}));
        hit_ctrl  = (paddr == AW'({`SPS_IDX_CTRL, 2'b00}));
        hit_csr   = (paddr == AW'({`SPS_IDX_CSR, 2'b00}));
        hit_mask  = (paddr == AW'({`SPS_IDX_MASK, 2'b00}));
        wr_data   = access_ph && pwrite && hit_data;
        wr_ctrl   = access_ph && pwrite && hit_ctrl;
        wr_csr    = access_ph && pwrite && hit_csr;
        wr_mask   = access_ph && pwrite && hit_mask;
        pready    = access_ph;
        pslverr   = access_ph && pslverr_r;
        prdata    = prdata_r;
    end

    // Read data is caught in the setup cycle so prdata comes from a flop
    always_comb begin
        rd_val = 8'h00;
        if (hit_data) begin
            rd_val = rx_buf_r;
        end else if (hit_ctrl) begin
            rd_val = ctrl_r;
        end else if (hit_csr) begin
            rd_val = csr_r & (`SPS_CSR_FLAGS | `SPS_CSR_WBITS);
        end else if (hit_mask) begin
            rd_val = mask_r & `SPS_CSR_FLAGS;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            prdata_r  <= {24'h00_0000, rd_val};
            pslverr_r <= !(hit_data || hit_ctrl || hit_csr || hit_mask);
        end
    end

    // ============================================================
    // Mode and select
    always_comb begin
        enabled   = ctrl_r[`SPS_CTRL_EN];
        is_master = ctrl_r[`SPS_CTRL_MASTER_SELECT];
        cpol      = ctrl_r[`SPS_CTRL_CPOL];
        cpha      = ctrl_r[`SPS_CTRL_CPHA];
        rate      = {ctrl_r[`SPS_CTRL_R2], ctrl_r[`SPS_CTRL_R1], ctrl_r[`SPS_CTRL_R0]};
        ss_int    = csr_r[`SPS_CSR_SSM] ? csr_r[`SPS_CSR_SSI] : ss_n_in;
        slave_sel = enabled && !is_master && !ss_int;
        master_run = (state_r == SPS_MRUN);
        // Select low while master means a second master on the bus
        mode_fault_flag_ev   = enabled && is_master && !ss_int;
    end

    // ============================================================
    // Clock edges
    sps_rate_gen #(
        .CNT_W (CNT_W)
    ) u_rate (
        .sys_clk (sys_clk),
        .rst     (rst),
        .run     (master_run),
        .rate    (rate),
        .tick    (tick)
    );

    // Slave clock is seen by comparing samples, hence the speed limit
    always_comb begin
        if (master_run) begin
            edge_ev = tick;
        end else begin
            edge_ev = slave_sel && (sck_in != sck_prev_r);
        end
        sample_edge = edge_ev && (edge_cnt_r[0] == cpha);
        drive_edge  = edge_ev && (edge_cnt_r[0] != cpha);
        last_edge   = edge_ev && (edge_cnt_r == `SPS_LAST_EDGE);
        in_pin      = is_master ? miso_in : mosi_in;
        // Phase 1 last bit bypasses in_bit_r, so the input pin is taken straight on that sampling edge
        shift_in    = (last_edge && cpha) ? in_pin : in_bit_r;
        shift_en    = drive_edge && (edge_cnt_r != 4'h0);
        rx_byte     = {sh_q[6:0], shift_in};
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sck_prev_r <= 1'b0;
        end else begin
            sck_prev_r <= sck_in;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            in_bit_r <= 1'b0;
        end else if (sample_edge) begin
            in_bit_r <= in_pin;
        end
    end

    // Slave count restarts whenever select goes high
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            edge_cnt_r <= 4'h0;
        end else if (mode_fault_flag_ev || !(master_run || slave_sel)) begin
            edge_cnt_r <= 4'h0;
        end else if (edge_ev) begin
            edge_cnt_r <= edge_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sck_r <= 1'b0;
        end else if (!master_run) begin
            sck_r <= cpol;
        end else if (tick) begin
            sck_r <= !sck_r;
        end
    end

    // ============================================================
    // Sequencer
    always_comb begin
        busy = master_run || (state_r == SPS_SRUN) ||
               (!is_master && !cpha && !ss_int && !ss_high_seen_r);
        write_collision_flag_ev      = wr_data && enabled && busy;
        load_en      = wr_data && !write_collision_flag_ev;
        start_master = load_en && enabled && is_master && ss_int && (state_r == SPS_IDLE);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ss_high_seen_r <= 1'b0;
        end else if (ss_int) begin
            ss_high_seen_r <= 1'b1;
        end else if (last_edge) begin
            ss_high_seen_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= SPS_IDLE;
        end else begin
            case (state_r)
                SPS_IDLE: begin
                    if (start_master) begin
                        state_r <= SPS_MRUN;
                    end else if (edge_ev && !last_edge && !is_master) begin
                        state_r <= SPS_SRUN;
                    end
                end
                SPS_MRUN: begin
                    if (mode_fault_flag_ev || last_edge || !enabled) begin
                        state_r <= SPS_IDLE;
                    end
                end
                SPS_SRUN: begin
                    if (last_edge || !slave_sel) begin
                        state_r <= SPS_IDLE;
                    end
                end
                default: begin
                    state_r <= SPS_IDLE;
                end
            endcase
        end
    end

    sps_shift8 #(
        .W (8)
    ) u_shift (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .load     (load_en),
        .load_val (pwdata[7:0]),
        .shift    (shift_en),
        .shift_in (shift_in),
        .q        (sh_q)
    );

    // ============================================================
    // Registers
    // Unread byte is kept; a new one arriving over it only raises overrun
    always_comb begin
        ovr_ev   = last_edge && csr_r[`SPS_CSR_DONE];
        flag_set = {last_edge, write_collision_flag_ev, ovr_ev, mode_fault_flag_ev, 4'h0};
        flag_clr = wr_csr ? (pwdata[7:0] & `SPS_CSR_FLAGS) : 8'h00;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_buf_r <= `SPS_DATA_RST;
        end else if (last_edge && !ovr_ev) begin
            rx_buf_r <= rx_byte;
        end
    end

    // Mode fault drops the port back to a disabled slave
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= `SPS_CTRL_RST;
        end else if (mode_fault_flag_ev) begin
            ctrl_r[`SPS_CTRL_EN]   <= 1'b0;
            ctrl_r[`SPS_CTRL_MASTER_SELECT] <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_r <= pwdata[7:0];
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            csr_r <= `SPS_CSR_RST;
        end else begin
            csr_r[7:4] <= ((csr_r[7:4] & ~flag_clr[7:4]) | flag_set[7:4]);
            csr_r[3]   <= 1'b0;
            if (wr_csr) begin
                csr_r[2:0] <= pwdata[2:0];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mask_r <= `SPS_MASK_RST;
        end else if (wr_mask) begin
            mask_r <= pwdata[7:0] & `SPS_CSR_FLAGS;
        end
    end

    // ============================================================
    // Pins and interrupt
    always_comb begin
        sck_out  = sck_r;
        sck_oe   = enabled && is_master;
        mosi_out = sh_q[7];
        mosi_oe  = enabled && is_master;
        miso_out = sh_q[7];
        // Output disable turns the slave into a two-line receiver
        miso_oe  = slave_sel && !csr_r[`SPS_CSR_SOD];
        irq      = ctrl_r[`SPS_CTRL_IRQEN] && ((csr_r & mask_r & `SPS_CSR_FLAGS) != 8'h00);
    end

endmodule

// ==== tb/sps_top_monitor.sv ====
// Purpose: Port checks of the serial port
// Assumes: One clock domain, zero wait state APB
// Notes:   Control bits are shadowed from APB writes
`timescale 1ns/10ps
`include "sps_params.svh"
module sps_top_monitor #(
    parameter int AW = 12
) (
    input wire logic          sys_clk,
    input wire logic          rst,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic          irq,
    input wire logic          sck_out,
    input wire logic          sck_oe,
    input wire logic          mosi_oe,
    input wire logic          miso_oe,
    input wire logic          ss_n_in
);
    // ============================================================
    // Shadows
    logic       irqen_r;
    logic [3:0] mask_r;
    logic       soft_sel_r;
    logic       mapped;
    assign mapped = paddr inside {AW'(12'h084), AW'(12'h088), AW'(12'h08c), AW'(12'h090)};
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irqen_r    <= 1'b0;
            mask_r     <= 4'h0;
            soft_sel_r <= 1'b0;
        end else if (psel && penable && pwrite) begin
            if (paddr == AW'(12'h088)) irqen_r <= pwdata[7];
            if (paddr == AW'(12'h090)) mask_r <= pwdata[7:4];
            if (paddr == AW'(12'h08c)) soft_sel_r <= pwdata[1];
        end
    end
    // ============================================================
    // Checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence sel_lost_s;
        sck_oe && !soft_sel_r && !ss_n_in;
    endsequence
    sequence oe_off_s;
        ##[1:4] !sck_oe;
    endsequence
    ready_wait_a:
        assert property (pready == (psel && penable)) else $error("pready wrong");
    rdata_high_a:
        assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("prdata high bits");
    slverr_map_a:
        assert property (pready |-> pslverr == !mapped) else $error("pslverr wrong");
    sck_half_a:
        assert property (sck_oe && $changed(sck_out) |=> $stable(sck_out) || !sck_oe) else $error("sck too fast");
    oe_pair_a:
        assert property (mosi_oe == sck_oe) else $error("enables differ");
    oe_drive_a:
        assert property (psel && penable && pwrite && paddr == AW'(12'h088) && pwdata[6] && pwdata[4]
            |=> sck_oe && mosi_oe) else $error("master pins not driven");
    oe_excl_a:
        assert property (!(miso_oe && sck_oe)) else $error("both roles");
    irq_gate_a:
        assert property (!irqen_r || mask_r == 4'h0 |-> !irq) else $error("irq unmasked");
    fault_drop_a:
        assert property (sel_lost_s |-> oe_off_s) else $error("no fault");
endmodule

bind sps_top sps_top_monitor #(.AW(AW)) sps_top_monitor_i (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
    .ss_n_in(ss_n_in));

// ==== tb/sps_slave_model.sv ====
// Purpose: External slave on the serial bus
// Assumes: Clock comes from the port under test
// Notes:   Released data line shows inverse of last bit
`timescale 1ns/10ps
module sps_slave_model (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    // ============================================================
    // Shifter, data moves on the edge opposite to sampling
    logic [7:0] sh;
    int         oi;
    initial begin
        {miso, rx_byte, sh} = '0;
        oi = 0;
    end
    always @(negedge sel_n) begin
        sh = tx_byte;
        oi = 0;
        if (!cpha) miso = sh[7];
    end
    always @(posedge sel_n) miso = ~miso;
    always @(sck) begin
        if (!sel_n) begin
            if ((sck != cpol) ^ cpha) begin
                rx_byte = {rx_byte[6:0], mosi};
            end else if (cpha) begin
                miso = sh[7-oi];
                oi = oi + 1;
            end else begin
                oi = oi + 1;
                if (oi < 8) miso = sh[7-oi];
            end
        end
    end
endmodule

// ==== tb/test_sps_top.sv ====
// Purpose: Self-checking bench of the serial port
// Assumes: Zero wait state APB; slave model on the bus
// Notes:   Bench acts as bus master in slave mode tests
`timescale 1ns/10ps
module test_sps_top;
    localparam logic [11:0] A_DATA = 12'h084;
    localparam logic [11:0] A_CTRL = 12'h088;
    localparam logic [11:0] A_CSR  = 12'h08c;
    localparam logic [11:0] A_MASK = 12'h090;
    logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq, er, sck_q;
    logic        sck_in, sck_out, sck_oe, mosi_in, mosi_out, mosi_oe, cpol, cpha;
    logic        miso_in, miso_out, miso_oe, ss_n_in, part_sel_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  stx, srx, rd, rx;
    int          error_cnt, n_tests, cyc, hc, gap;

    sps_top sps_top_i (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_in), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_in(miso_in), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n_in));
    sps_slave_model sps_slave_model_i (.sck(sck_out), .mosi(mosi_out), .sel_n(part_sel_n), .cpol(cpol),
        .cpha(cpha), .tx_byte(stx), .miso(miso_in), .rx_byte(srx));

    // ============================================================
    // Clock, timeout, clock half period
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc   <= cyc + 1;
        sck_q <= sck_out;
        hc    <= (sck_out !== sck_q) ? 1 : hc + 1;
        if (sck_out !== sck_q) gap <= hc;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            finish_test();
        end
    end

    // ============================================================
    // Tasks
    task automatic ck(input logic [31:0] s, input logic [31:0] e);
        n_tests = n_tests + 1;
        if (s !== e) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= {24'h0, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata[7:0];
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        ck(rd, e);
    endtask
    task automatic wait_done();
        rd = 8'h00;
        for (int i = 0; i < 800 && rd[7] !== 1'b1; i++) apb(1'b0, A_CSR, 8'h00);
        ck(rd[7], 1'b1);
    endtask
    // Half bit of four cycles keeps the bench clock slow enough
    task automatic xm(input logic [7:0] tx, input logic pin, input logic keep);
        if (pin) ss_n_in <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            // Data moves mid low phase, clear of both sampling edges
            repeat (2) @(posedge sys_clk);
            mosi_in <= tx[i];
            repeat (2) @(posedge sys_clk);
            sck_in <= 1'b1;
            repeat (4) @(posedge sys_clk);
            rx[i] = miso_out;
            sck_in <= 1'b0;
        end
        repeat (4) @(posedge sys_clk);
        mosi_in <= ~tx[0];
        if (!keep) ss_n_in <= 1'b1;
        @(posedge sys_clk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ============================================================
    // Tests
    initial begin
        {psel, penable, pwrite, sck_in, mosi_in, cpol, cpha, sck_q, part_sel_n, ss_n_in} = 10'h003;
        {paddr, pwdata, stx, rx, rd, er} = '0;
        {error_cnt, n_tests, cyc, hc, gap} = '0;
        rst = 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rdc(A_CTRL, 8'h00);
        rdc(A_CSR, 8'h00);
        rdc(A_MASK, 8'h00);
        apb(1'b0, 12'h094, 8'h00);
        ck(er, 1'b1);
        wr(A_CSR, 8'hff);
        rdc(A_CSR, 8'h07);
        wr(A_CSR, 8'h00);
        $display("test registers done");
        for (int r = 0; r < 8; r++) begin
            cpol <= r[0];
            cpha <= r[1];
            stx  <= 8'h3c + 8'(r * 17);
            wr(A_CTRL, {4'h0, r[0], 3'h0});
            wr(A_MASK, (r >= 3) ? 8'h80 : 8'h00);
            ck(sck_out, r[0]);
            wr(A_CTRL, {2'b11, r[2], 1'b1, r[0], r[1], r[1], r[0]});
            part_sel_n <= 1'b0;
            wr(A_DATA, 8'hc3 - 8'(r));
            if (r[0]) wr(A_DATA, 8'hff);
            wait_done();
            ck(gap, 2 << ((r > 5) ? 5 : r));
            ck(srx, 8'hc3 - 8'(r));
            ck(irq, r >= 3);
            rdc(A_CSR, {1'b1, r[0], 6'h00});
            rdc(A_DATA, 8'h3c + 8'(r * 17));
            part_sel_n <= 1'b1;
            wr(A_CSR, 8'hc0);
            ck(irq, 1'b0);
        end
        $display("test master done");
        wr(A_CTRL, 8'h50);
        ss_n_in <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rdc(A_CSR, 8'h10);
        rdc(A_CTRL, 8'h00);
        ss_n_in <= 1'b1;
        wr(A_CSR, 8'h10);
        $display("test fault done");
        wr(A_CTRL, 8'h40);
        wr(A_DATA, 8'h96);
        xm(8'h5a, 1'b1, 1'b1);
        ck(miso_oe, 1'b1);
        wait_done();
        ck(rx, 8'h96);
        rdc(A_DATA, 8'h5a);
        wr(A_DATA, 8'h11);
        rdc(A_CSR, 8'hc0);
        ss_n_in <= 1'b1;
        wr(A_CSR, 8'hc0);
        wr(A_DATA, 8'h11);
        rdc(A_CSR, 8'h00);
        $display("test slave phase 0 done");
        wr(A_CSR, 8'h02);
        wr(A_CTRL, 8'h44);
        wr(A_DATA, 8'h2d);
        xm(8'hb4, 1'b0, 1'b1);
        wait_done();
        ck(rx, 8'h2d);
        rdc(A_DATA, 8'hb4);
        xm(8'h69, 1'b0, 1'b1);
        rdc(A_CSR, 8'ha2);
        rdc(A_DATA, 8'hb4);
        wr(A_CSR, 8'h06);
        ck(miso_oe, 1'b0);
        $display("test slave phase 1 done");
        finish_test();
    end
endmodule
